/* hdl/nrxho_top.sv */
// Purpose: Receive header builder, buffer placement and control queue ack
// Assumes: Classic Wishbone slave, one-cycle answer, single clock
// Notes: Features come from software; packet metadata from a classifier
`default_nettype none
module nrxho_top #(
   parameter int unsigned LEN_W = 17
) (
   input wire logic clock,                     // 100 MHz system clock
   input wire logic rst,                       // Synchronous reset
   // Wishbone classic slave
   input wire logic wb_cyc_i,                  // Cycle
   input wire logic wb_stb_i,                  // Strobe
   input wire logic wb_we_i,                   // Write enable
   input wire logic [7:0] wb_adr_i,            // Byte address
   input wire logic [3:0] wb_sel_i,            // Byte lanes
   input wire logic [31:0] wb_dat_i,           // Write data
   output logic [31:0] wb_dat_o,               // Read data
   output logic wb_ack_o,                      // Acknowledge
   // Packet metadata from classifier
   input wire logic pktValid,                  // Packet ready to place
   input wire nrxho_pkg::nrxho_meta_t pktMeta, // Packet description
   output logic pktReady,                      // Packet accepted
   // Posted receive buffers
   input wire logic bufValid,                  // Buffer offered
   input wire logic [LEN_W-1:0] bufLen,        // Its length
   output logic bufTake,                       // Buffer consumed
   output logic [LEN_W-1:0] bufFill,           // Bytes written
   // Completed header and used-ring release
   output nrxho_pkg::nrxho_hdr_t hdrOut,       // Header of first buffer
   output logic usedPost,                      // Release all buffers now
   output logic [15:0] usedCount,              // Number to release
   // Control queue command
   input wire logic ctrlValid,                 // Command fetched
   input wire nrxho_pkg::nrxho_ctrl_t ctrlIn,  // Class, command, verdict
   output logic ctrlAckValid,                  // Ack byte written
   output logic [7:0] ctrlAck,                 // Ack value
   output logic ctrlUsed                       // Control buffer returned
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PLACE = 2'b01,
      ST_POST = 2'b10
   } nrxho_state_t;

   logic [7:0] features;
   logic [15:0] dropCount;
   logic [15:0] ctrlCount;
   nrxho_state_t state;
   nrxho_pkg::nrxho_meta_t meta;
   nrxho_pkg::nrxho_hdr_t hdr;
   logic splitStart;
   logic splitDone;
   logic splitBusy;
   logic splitBig;
   logic [15:0] splitCount;
   logic ctrlPending;
   logic [7:0] pendAck;
   logic [16:0] limit;
   logic gsoOn;

   function automatic logic anyGso(input logic [7:0] f);
      anyGso = f[nrxho_pkg::F_TSO4] | f[nrxho_pkg::F_TSO6] | f[nrxho_pkg::F_UFO];
   endfunction : anyGso

   // ----------------------------------------
   // Header field construction
   // ----------------------------------------
   function automatic nrxho_pkg::nrxho_hdr_t buildHdr(
      input nrxho_pkg::nrxho_meta_t m,
      input logic [7:0] f
   );
      nrxho_pkg::nrxho_hdr_t h;
      logic segOk;
      h = '0;
      segOk = 1'b0;
      case (m.segKind)
         2'd1: segOk = f[nrxho_pkg::F_TSO4];
         2'd2: segOk = f[nrxho_pkg::F_TSO6];
         2'd3: segOk = f[nrxho_pkg::F_UFO];
         default: segOk = 1'b0;
      endcase
      // Checksum flags need the guest checksum feature
      if (f[nrxho_pkg::F_CSUM]) begin
         if (m.csumPartial) begin
            h.flags = h.flags | nrxho_pkg::FLAG_NEEDS_CSUM;
            h.csumStart = m.csumStart;
            h.csumOffset = m.csumOffset;
         end
         if (m.csumValid) begin
            h.flags = h.flags | nrxho_pkg::FLAG_DATA_VALID;
         end
         // Segmentation is only reported when checksum can be flagged too
         if (segOk) begin
            case (m.segKind)
               2'd1: h.gsoType = nrxho_pkg::GSO_TCPV4;
               2'd2: h.gsoType = nrxho_pkg::GSO_TCPV6;
               default: h.gsoType = nrxho_pkg::GSO_UDP;
            endcase
            if (m.ecn && f[nrxho_pkg::F_ECN] && m.segKind != 2'd3) begin
               h.gsoType = h.gsoType | nrxho_pkg::GSO_ECN;
            end
            h.flags = h.flags | nrxho_pkg::FLAG_NEEDS_CSUM;
            h.gsoSize = m.mss;
            h.csumStart = m.csumStart;
            h.csumOffset = m.csumOffset;
            if (f[nrxho_pkg::F_RSC]) begin
               h.flags = h.flags | nrxho_pkg::FLAG_RSC_INFO;
               h.csumStart = m.coalesced;
               h.csumOffset = m.dupAcks;
            end
         end
      end
      if (anyGso(f)) begin
         h.hdrLen = m.hdrLen;
      end
      buildHdr = h;
   endfunction : buildHdr

   assign gsoOn = anyGso(features);
   assign limit = gsoOn ? 17'(nrxho_pkg::MAX_PKT_GSO) : 17'(nrxho_pkg::MAX_PKT_STD);
   assign splitStart = (state == ST_IDLE) && pktValid && (pktMeta.length <= limit);

   // Segmented ECN packets without ECN support are dropped
   function automatic logic dropIt(
      input nrxho_pkg::nrxho_meta_t m,
      input logic [7:0] f,
      input logic [16:0] lim
   );
      dropIt = (m.length > lim)
         || (m.ecn && m.segKind != 2'd0 && !f[nrxho_pkg::F_ECN]);
   endfunction : dropIt

   nrxho_buf_splitter #(
      .LEN_W(LEN_W),
      .CNT_W(16)
   ) u_split (
      .clock(clock),
      .rst(rst),
      .start(splitStart && !dropIt(pktMeta, features, limit)),
      .total(LEN_W'(pktMeta.length + 17'(nrxho_pkg::HDR_BYTES))),
      .merge(features[nrxho_pkg::F_MRG]),
      .bufValid(bufValid),
      .bufLen(bufLen),
      .bufTake(bufTake),
      .bufFill(bufFill),
      .busy(splitBusy),
      .done(splitDone),
      .tooBig(splitBig),
      .count(splitCount)
   );

   // ----------------------------------------
   // Packet sequencing
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= ST_IDLE;
         meta <= '0;
         hdr <= '0;
         pktReady <= 1'b0;
         hdrOut <= '0;
         usedPost <= 1'b0;
         usedCount <= 16'h0000;
      end else begin
         pktReady <= 1'b0;
         usedPost <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (pktValid && !pktReady) begin
                  pktReady <= 1'b1;
                  meta <= pktMeta;
                  hdr <= buildHdr(pktMeta, features);
                  if (!dropIt(pktMeta, features, limit)) begin
                     state <= ST_PLACE;
                  end
               end
            end
            ST_PLACE: begin
               if (splitDone) begin
                  state <= ST_POST;
               end
            end
            ST_POST: begin
               hdrOut <= hdr;
               // Count written into the first buffer's header
               hdrOut.numBuffers <= features[nrxho_pkg::F_MRG] ? splitCount
                                    : 16'h0001;
               usedCount <= splitCount;
               usedPost <= 1'b1;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         dropCount <= 16'h0000;
      end else if (state == ST_IDLE && pktValid && !pktReady
                   && dropIt(pktMeta, features, limit)) begin
         dropCount <= dropCount + 16'h0001;
      end else if (state == ST_PLACE && splitDone && splitBig) begin
         dropCount <= dropCount + 16'h0001;
      end
   end

   // ----------------------------------------
   // Control queue acknowledge
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrlPending <= 1'b0;
         pendAck <= nrxho_pkg::ACK_OK;
         ctrlAckValid <= 1'b0;
         ctrlAck <= nrxho_pkg::ACK_OK;
         ctrlUsed <= 1'b0;
         ctrlCount <= 16'h0000;
      end else begin
         ctrlAckValid <= 1'b0;
         ctrlUsed <= 1'b0;
         if (ctrlPending) begin
            // Ack only after processing finished, then release the buffer
            ctrlAckValid <= 1'b1;
            ctrlAck <= pendAck;
            ctrlPending <= 1'b0;
         end else if (ctrlAckValid) begin
            ctrlUsed <= 1'b1;
         end else if (ctrlValid && features[nrxho_pkg::F_CTRLQ]) begin
            ctrlPending <= 1'b1;
            pendAck <= ctrlIn.cmdOk ? nrxho_pkg::ACK_OK : nrxho_pkg::ACK_ERR;
            ctrlCount <= ctrlCount + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Wishbone register access
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         features <= nrxho_pkg::FEAT_RESET;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                   && wb_adr_i == nrxho_pkg::REG_FEAT && wb_sel_i[0]) begin
         features <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         case (wb_adr_i)
            nrxho_pkg::REG_FEAT: wb_dat_o <= {24'h000000, features};
            nrxho_pkg::REG_STAT: wb_dat_o <= {dropCount, 13'h0000, splitBusy,
                                              state};
            nrxho_pkg::REG_HDR0: wb_dat_o <= {hdrOut.hdrLen, hdrOut.gsoType,
                                              hdrOut.flags};
            nrxho_pkg::REG_HDR1: wb_dat_o <= {hdrOut.csumStart, hdrOut.gsoSize};
            nrxho_pkg::REG_HDR2: wb_dat_o <= {hdrOut.numBuffers, hdrOut.csumOffset};
            nrxho_pkg::REG_CTRL: wb_dat_o <= {ctrlCount, 8'h00, ctrlAck};
            default: wb_dat_o <= nrxho_pkg::UNMAPPED_READ;
         endcase
      end
   end
endmodule : nrxho_top
`default_nettype wire

/* hdl/nrxho_pkg.sv */
// Purpose: Shared constants and types for the receive header offload block
// Assumes: Wishbone classic register access, 32-bit data
// Notes: Header fields are little-endian 16-bit words after flags and gso type
`default_nettype none
package nrxho_pkg;
   // Sizes
   localparam int unsigned HDR_BYTES = 12;
   localparam int unsigned MAX_PKT_GSO = 65550;
   localparam int unsigned MAX_PKT_STD = 1514;
   // Register offsets (byte addresses)
   localparam logic [7:0] REG_FEAT = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_HDR0 = 8'h08;
   localparam logic [7:0] REG_HDR1 = 8'h0C;
   localparam logic [7:0] REG_HDR2 = 8'h10;
   localparam logic [7:0] REG_CTRL = 8'h14;
   // Feature bit positions
   localparam int unsigned F_CSUM = 0;
   localparam int unsigned F_TSO4 = 1;
   localparam int unsigned F_TSO6 = 2;
   localparam int unsigned F_UFO = 3;
   localparam int unsigned F_ECN = 4;
   localparam int unsigned F_MRG = 5;
   localparam int unsigned F_RSC = 6;
   localparam int unsigned F_CTRLQ = 7;
   localparam logic [7:0] FEAT_RESET = 8'h00;
   // Header flags
   localparam logic [7:0] FLAG_NEEDS_CSUM = 8'h01;
   localparam logic [7:0] FLAG_DATA_VALID = 8'h02;
   localparam logic [7:0] FLAG_RSC_INFO = 8'h04;
   // Segmentation types
   localparam logic [7:0] GSO_NONE = 8'h00;
   localparam logic [7:0] GSO_TCPV4 = 8'h01;
   localparam logic [7:0] GSO_UDP = 8'h03;
   localparam logic [7:0] GSO_TCPV6 = 8'h04;
   localparam logic [7:0] GSO_ECN = 8'h80;
   // Acknowledge values
   localparam logic [7:0] ACK_OK = 8'h00;
   localparam logic [7:0] ACK_ERR = 8'h01;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] gsoType;
      logic [15:0] hdrLen;
      logic [15:0] gsoSize;
      logic [15:0] csumStart;
      logic [15:0] csumOffset;
      logic [15:0] numBuffers;
   } nrxho_hdr_t;

   // Packet metadata from the receive classifier
   typedef struct packed {
      logic [16:0] length;
      logic [1:0] segKind;    // 0 none, 1 tcp4, 2 tcp6, 3 udp
      logic ecn;
      logic csumPartial;
      logic csumValid;
      logic [15:0] mss;
      logic [15:0] hdrLen;
      logic [15:0] csumStart;
      logic [15:0] csumOffset;
      logic [15:0] coalesced;
      logic [15:0] dupAcks;
   } nrxho_meta_t;

   typedef struct packed {
      logic [7:0] cls;
      logic [7:0] cmd;
      logic cmdOk;
   } nrxho_ctrl_t;
endpackage : nrxho_pkg
`default_nettype wire

/* hdl/nrxho_buf_splitter.sv */
// Purpose: Spreads one packet plus header over posted receive buffers
// Assumes: Buffer lengths of at least the header size when merging
// Notes: Returns buffers only once the packet is placed whole or truncated
`default_nettype none
module nrxho_buf_splitter #(
   parameter int unsigned LEN_W = 17,
   parameter int unsigned CNT_W = 16
) (
   input wire logic clock,                // System clock
   input wire logic rst,                  // Synchronous reset
   input wire logic start,                // Begin placing a packet
   input wire logic [LEN_W-1:0] total,    // Header plus packet bytes
   input wire logic merge,                // Merged buffers allowed
   input wire logic bufValid,             // A posted buffer is offered
   input wire logic [LEN_W-1:0] bufLen,   // Length of offered buffer
   output logic bufTake,                  // Offered buffer consumed
   output logic [LEN_W-1:0] bufFill,      // Bytes written into it
   output logic busy,                     // Placement in progress
   output logic done,                     // Placement ended, whole or truncated
   output logic tooBig,                   // Single buffer too short
   output logic [CNT_W-1:0] count         // Buffers consumed
);
   logic [LEN_W-1:0] remain;

   always_ff @(posedge clock) begin
      if (rst) begin
         remain <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         tooBig <= 1'b0;
         count <= '0;
         bufTake <= 1'b0;
         bufFill <= '0;
      end else begin
         done <= 1'b0;
         bufTake <= 1'b0;
         if (start && !busy) begin
            remain <= total;
            busy <= 1'b1;
            count <= '0;
            tooBig <= 1'b0;
         end else if (busy && bufValid && !bufTake) begin
            bufTake <= 1'b1;
            count <= count + 1'b1;
            if (remain <= bufLen) begin
               bufFill <= remain;
               busy <= 1'b0;
               done <= 1'b1;
            end else if (!merge) begin
               // Truncate rather than spill into a second chain
               bufFill <= bufLen;
               tooBig <= 1'b1;
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               bufFill <= bufLen;
               remain <= remain - bufLen;
            end
         end
      end
   end
endmodule : nrxho_buf_splitter
`default_nettype wire

/* tb/nrxho_top_props.sv */
// Purpose: Port-level checks of the receive header block
// Assumes: Feature shadow follows acknowledged writes to FEAT
// Notes: Bound to every nrxho_top instance
`default_nettype none
module nrxho_top_props #(
   parameter int unsigned LEN_W = 17
) (
   input wire logic clock,                     // Clock
   input wire logic rst,                       // Reset
   input wire logic wb_cyc_i,                  // Cycle
   input wire logic wb_stb_i,                  // Strobe
   input wire logic wb_we_i,                   // Write
   input wire logic [7:0] wb_adr_i,            // Address
   input wire logic [3:0] wb_sel_i,            // Lanes
   input wire logic [31:0] wb_dat_i,           // Write data
   input wire logic wb_ack_o,                  // Acknowledge
   input wire logic pktValid,                  // Packet offered
   input wire nrxho_pkg::nrxho_meta_t pktMeta, // Metadata
   input wire logic pktReady,                  // Packet taken
   input wire logic [LEN_W-1:0] bufLen,        // Offered length
   input wire logic bufTake,                   // Buffer used
   input wire logic [LEN_W-1:0] bufFill,       // Bytes written
   input wire nrxho_pkg::nrxho_hdr_t hdrOut,   // Header
   input wire logic usedPost,                  // Release
   input wire logic [15:0] usedCount,          // Release count
   input wire logic ctrlValid,                 // Command
   input wire nrxho_pkg::nrxho_ctrl_t ctrlIn,  // Verdict
   input wire logic ctrlAckValid,              // Ack written
   input wire logic [7:0] ctrlAck,             // Ack value
   input wire logic ctrlUsed                   // Returned
);
   logic [7:0] feat;
   logic [15:0] takes;
   logic [15:0] mss;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Shadow state
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst)
         feat <= 8'h00;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
               && wb_adr_i == nrxho_pkg::REG_FEAT)
         feat <= wb_dat_i[7:0];
   end
   always_ff @(posedge clock) begin
      if (rst || pktReady)
         takes <= 16'h0000;
      else if (bufTake)
         takes <= takes + 16'h0001;
   end
   always_ff @(posedge clock) begin
      if (pktValid && pktReady)
         mss <= pktMeta.mss;
   end
   a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no acknowledge one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   a_single_buf: assert property (usedPost && !feat[nrxho_pkg::F_MRG] |->
      hdrOut.numBuffers == 16'h0001 && usedCount == 16'h0001)
      else $error("unmerged packet not in one buffer");
   a_count_all: assert property (usedPost |->
      usedCount == takes && hdrOut.numBuffers == takes)
      else $error("buffer count differs from buffers taken");
   a_fill_full: assert property (bufTake && bufFill != bufLen |-> ##[1:3] usedPost)
      else $error("partly filled buffer was not the last");
   a_flags_zero: assert property (usedPost && !feat[nrxho_pkg::F_CSUM] |->
      hdrOut.flags == 8'h00)
      else $error("flags set without checksum feature");
   a_gso_gate: assert property (usedPost |->
      (hdrOut.gsoType[6:0] != 7'h01 || feat[nrxho_pkg::F_TSO4])
      && (hdrOut.gsoType[6:0] != 7'h04 || feat[nrxho_pkg::F_TSO6])
      && (hdrOut.gsoType[6:0] != 7'h03 || feat[nrxho_pkg::F_UFO]))
      else $error("segment type without its feature");
   a_ecn_gate: assert property (usedPost && hdrOut.gsoType[7] |-> feat[nrxho_pkg::F_ECN])
      else $error("congestion bit without its feature");
   a_seg_mss: assert property (usedPost && hdrOut.gsoType != nrxho_pkg::GSO_NONE |->
      hdrOut.flags[0] && hdrOut.gsoSize == mss)
      else $error("segmented packet lacks checksum flag or size");
   a_rsc_gate: assert property (usedPost && hdrOut.flags[2] |-> feat[nrxho_pkg::F_RSC])
      else $error("coalescing flag without extension");
   a_ctrl_gate: assert property (ctrlValid && !feat[nrxho_pkg::F_CTRLQ] |-> ##2 !ctrlAckValid)
      else $error("control answered while disabled");
   a_ctrl_ack: assert property (ctrlAckValid |->
      ctrlAck == ($past(ctrlIn.cmdOk, 2) ? nrxho_pkg::ACK_OK : nrxho_pkg::ACK_ERR) ##1 ctrlUsed)
      else $error("wrong ack value or buffer not returned");
   c_multi: cover property (usedPost && usedCount > 16'h0001);
   c_ecn: cover property (usedPost && hdrOut.gsoType[7]);
   c_err: cover property (ctrlAckValid && ctrlAck == nrxho_pkg::ACK_ERR);
endmodule : nrxho_top_props
bind nrxho_top nrxho_top_props #(.LEN_W(LEN_W)) u_props (.clock(clock), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .pktValid(pktValid),
   .pktMeta(pktMeta), .pktReady(pktReady), .bufLen(bufLen), .bufTake(bufTake),
   .bufFill(bufFill), .hdrOut(hdrOut), .usedPost(usedPost), .usedCount(usedCount),
   .ctrlValid(ctrlValid), .ctrlIn(ctrlIn), .ctrlAckValid(ctrlAckValid), .ctrlAck(ctrlAck),
   .ctrlUsed(ctrlUsed));
`default_nettype wire

/* tb/nrxho_drv_model.sv */
// Purpose: Guest driver side that posts receive buffers
// Assumes: Posted lengths never below the header size
// Notes: Idle length lines toggle so stale values never pass
`default_nettype none
module nrxho_drv_model (
   input wire logic clock,        // Clock
   input wire logic rst,          // Reset
   input wire logic offer,        // Keep the queue stocked
   input wire logic slow,         // Pause a cycle after each take
   input wire logic [16:0] size,  // Posted buffer length
   input wire logic bufTake,      // Buffer consumed
   output logic bufValid,         // Buffer offered
   output logic [16:0] bufLen     // Its length
);
   always_ff @(posedge clock) begin
      if (rst)
         bufValid <= 1'b0;
      else if (!bufValid || bufTake || !offer)
         bufValid <= offer && !(slow && bufValid);
   end
   always_ff @(posedge clock) begin
      if (rst)
         bufLen <= 17'h15555;
      else if (!bufValid || bufTake || !offer)
         bufLen <= (offer && !(slow && bufValid)) ? size : ~bufLen;
   end
endmodule : nrxho_drv_model
`default_nettype wire

/* tb/test_nrxho_top.sv */
// Purpose: Directed bench for the receive header block
// Assumes: One-cycle Wishbone answer, packets spaced by release
// Notes: Header fields compared against values worked out here
`default_nettype none
module test_nrxho_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat, rd;
   logic ack, pktReady, bufValid, bufTake, usedPost, ctrlAckValid, ctrlUsed;
   logic pktValid = 1'b0;
   logic offer = 1'b0;
   logic slow = 1'b0;
   logic ctrlValid = 1'b0;
   logic [16:0] size = 17'h005F6;
   logic [16:0] bufLen, bufFill;
   logic [15:0] usedCount, uc;
   logic [7:0] ctrlAck;
   nrxho_pkg::nrxho_meta_t meta = '{17'h00000, 2'h0, 1'b0, 1'b1, 1'b0, 16'h05B4,
      16'h0036, 16'h0022, 16'h0010, 16'h0003, 16'h0002};
   nrxho_pkg::nrxho_ctrl_t ctrlIn = '{8'h01, 8'h02, 1'b0};
   nrxho_pkg::nrxho_hdr_t hdrOut, hd;
   int failures = 0;
   int comparisons = 0;
   always #5 clock = ~clock;
   nrxho_top #(.LEN_W(17)) u_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .pktValid(pktValid), .pktMeta(meta), .pktReady(pktReady),
      .bufValid(bufValid), .bufLen(bufLen), .bufTake(bufTake), .bufFill(bufFill),
      .hdrOut(hdrOut), .usedPost(usedPost), .usedCount(usedCount), .ctrlValid(ctrlValid),
      .ctrlIn(ctrlIn), .ctrlAckValid(ctrlAckValid), .ctrlAck(ctrlAck), .ctrlUsed(ctrlUsed));
   nrxho_drv_model u_drv (.clock(clock), .rst(rst), .offer(offer), .slow(slow),
      .size(size), .bufTake(bufTake), .bufValid(bufValid), .bufLen(bufLen));
   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      @(posedge clock);
      while (ack !== 1'b1) @(posedge clock);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock);
   endtask : wb
   task automatic pkt(input logic [16:0] len, input logic [1:0] kind, input logic ecn,
                      input logic drop);
      meta.length <= len;
      meta.segKind <= kind;
      meta.ecn <= ecn;
      pktValid <= 1'b1;
      @(posedge clock);
      while (pktReady !== 1'b1) @(posedge clock);
      pktValid <= 1'b0;
      while (!drop && usedPost !== 1'b1) @(posedge clock);
      hd = hdrOut;
      uc = usedCount;
      repeat (3) @(posedge clock);
   endtask : pkt
   task automatic hchk(input logic [7:0] f, input logic [7:0] g, input logic [15:0] nb);
      check("flags", 32'(hd.flags), 32'(f));
      check("gso", 32'(hd.gsoType), 32'(g));
      check("bufs", 32'(hd.numBuffers), 32'(nb));
      check("used", 32'(uc), 32'(nb));
      check("unknown", 32'(hd.flags & 8'hF8), 32'h00000000);
   endtask : hchk
   task automatic ctl(input logic ok, input logic on);
      int n;
      n = 0;
      ctrlIn.cmdOk <= ok;
      ctrlValid <= 1'b1;
      @(posedge clock);
      ctrlValid <= 1'b0;
      while (ctrlAckValid !== 1'b1 && n < 4) begin
         @(posedge clock);
         n++;
      end
      check("ackseen", 32'(ctrlAckValid), 32'(on));
      if (on) begin
         check("ack", 32'(ctrlAck), 32'(ok ? 8'h00 : 8'h01));
         @(posedge clock);
         check("ctrlused", 32'(ctrlUsed), 32'h00000001);
      end
      repeat (4) @(posedge clock);
   endtask : ctl
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   initial begin
      #300000;
      failures++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      wb(1'b0, nrxho_pkg::REG_FEAT, 32'h00000000);
      check("feat", rd, 32'h00000000);
      wb(1'b0, 8'h40, 32'h00000000);
      check("unmapped", rd, nrxho_pkg::UNMAPPED_READ);
      $display("Test registers done");
      offer <= 1'b1;
      pkt(17'h005EA, 2'h1, 1'b0, 1'b0);
      hchk(8'h00, nrxho_pkg::GSO_NONE, 16'h0001);
      // Withdraw the spare large buffer so offload packets see small ones
      offer <= 1'b0;
      pkt(17'h005EB, 2'h0, 1'b0, 1'b1);
      wb(1'b0, nrxho_pkg::REG_STAT, 32'h00000000);
      check("drops", 32'(rd[31:16]), 32'h00000001);
      $display("Test plain receive done");
      // Checksum, all segment kinds, coalescing, merging
      wb(1'b1, nrxho_pkg::REG_FEAT, 32'h0000006F);
      size <= 17'h00040;
      slow <= 1'b1;
      offer <= 1'b1;
      for (int k = 1; k < 4; k++) begin
         pkt(17'h000C8, 2'(k), 1'b0, 1'b0);
         hchk(8'h05, k == 1 ? 8'h01 : (k == 2 ? 8'h04 : 8'h03), 16'h0004);
         check("cstart", 32'(hd.csumStart), 32'h00000003);
         check("coff", 32'(hd.csumOffset), 32'h00000002);
         check("hdrlen", 32'(hd.hdrLen >= 16'h0036), 32'h00000001);
      end
      pkt(17'h005EB, 2'h0, 1'b0, 1'b0);
      hchk(8'h01, nrxho_pkg::GSO_NONE, 16'h0018);
      check("cstart", 32'(hd.csumStart), 32'h00000022);
      check("coff", 32'(hd.csumOffset), 32'h00000010);
      $display("Test offload receive done");
      pkt(17'h000C8, 2'h1, 1'b1, 1'b1);
      wb(1'b0, nrxho_pkg::REG_STAT, 32'h00000000);
      check("drops", 32'(rd[31:16]), 32'h00000002);
      wb(1'b1, nrxho_pkg::REG_FEAT, 32'h0000007F);
      pkt(17'h000C8, 2'h1, 1'b1, 1'b0);
      hchk(8'h05, 8'h81, 16'h0004);
      wb(1'b0, nrxho_pkg::REG_HDR0, 32'h00000000);
      check("hdr0", rd, 32'h00368105);
      $display("Test congestion done");
      ctl(1'b1, 1'b0);
      wb(1'b1, nrxho_pkg::REG_FEAT, 32'h000000FF);
      ctl(1'b1, 1'b1);
      ctl(1'b0, 1'b1);
      wb(1'b0, nrxho_pkg::REG_CTRL, 32'h00000000);
      check("ctrlreg", rd, 32'h00020001);
      $display("Test control done");
      // Merging off with a short buffer: one buffer, truncated, counted
      wb(1'b1, nrxho_pkg::REG_FEAT, 32'h000000DF);
      pkt(17'h000C8, 2'h0, 1'b0, 1'b0);
      hchk(8'h01, nrxho_pkg::GSO_NONE, 16'h0001);
      wb(1'b0, nrxho_pkg::REG_STAT, 32'h00000000);
      check("drops", 32'(rd[31:16]), 32'h00000003);
      $display("Test truncation done");
      end_sim();
   end
endmodule : test_nrxho_top
`default_nettype wire
